// File: core/usart_clock_and_framing.sv
// Baud generation, transfer clock handling and serial framing
// Summary of operation
// RL1 - Divisor clock except in sync slave, which takes the pin clock
// RL2 - Down-counter reloads at zero and on each low divisor write
// RL3 - One pulse per zero; rate is pclk over divisor plus one
// RL4 - Transmitter divides generator output by 16, 8 or 2
// RL5 - Receiver runs 16, 8 or 2 states straight off the generator
// RL6 - Divisor is 12 bits from high and low bytes, 0 to 4095
// RL7 - Double speed acts in async only; keep it clear for sync
// RL8 - Double speed receiver takes 8 samples per bit, not 16
// RL9 - Pin clock passes a synchroniser then an edge detector
// RL10 - Synchroniser and edge detector add two pclk periods
// RL11 - Remote pin clock stays below a quarter of pclk
// RL12 - Sync clock pin is input for slave, output for master
// RL13 - Input sampled on the edge opposite the data change edge
// RL14 - Polarity low: change on rise, sample on fall; high: reverse
// RL15 - Low start, 5-9 data LSB first, parity option, 1-2 stops
// RL16 - Line idles high; next frame may follow the stop directly
// RL17 - Char size, parity mode and stop select set the format
// RL18 - Second stop ignored; frame error only for low first stop
// RL19 - One format serves both directions; changes corrupt frames
// RL20 - Parity is xor of data bits, inverted for odd
// RL21 - Parity bit sits after last data bit, before first stop
// RL22 - Software idles transmitter before changing divisor or format
// RL23 - Software clears transmit complete before each data write
// RL24 - Sync mode select low is async, high is sync
// RL25 - Clock direction picks master or slave clock in sync mode
// RL26 - High byte is staged; low byte write applies whole divisor
// RL27 - Short characters send only the configured low data bits
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module usart_clock_and_framing (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [usart_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial data
   input wire logic serial_in,
   output logic serial_out,
   // Transfer clock pin
   input wire logic xfer_clock_pin_in,
   output logic xfer_clock_pin_out,
   output logic xfer_clock_pin_oe_n
);
   import usart_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [7:0] div_low;
   logic [3:0] div_high_hold;
   logic [11:0] baud_divisor;
   logic double_speed;
   logic [2:0] char_size;
   logic [1:0] parity_mode;
   logic stop_bit_select;
   logic sync_mode_select;
   logic clock_polarity;
   logic xfer_clock_direction;
   logic tx_complete_flag;
   logic rx_complete_flag;
   logic frame_error_flag;
   logic parity_error_flag;
   logic [8:0] tx_hold;
   logic tx_pending;
   logic [8:0] rx_data;
   logic setup;
   logic access;
   logic wr_acc;
   logic addr_ok;
   logic wr_low;
   logic wr_high;
   logic wr_csa;
   logic wr_csc;
   logic wr_data;
   logic rd_data;
   logic [31:0] next_rdata;
   mode_e mode;
   logic is_async;
   logic [4:0] spb;
   logic [4:0] spb_m1;
   logic [3:0] half;
   logic baud_tick;
   logic xck_rise;
   logic xck_fall;
   logic xck_int;
   logic [3:0] tx_div;
   logic tx_en;
   logic sync_samp;
   logic [3:0] nb;
   logic [12:0] tx_frame;
   logic [3:0] tx_len;
   logic [12:0] tx_shift;
   logic [3:0] tx_cnt;
   logic tx_busy;
   logic tx_load;
   logic tx_done;
   logic rx_meta;
   logic rx_in;
   rx_state_e rx_state;
   logic [3:0] rx_phase;
   logic [3:0] rx_idx;
   logic [8:0] rx_shift;
   logic rx_par;
   logic rx_samp;
   logic rx_finish;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr_acc = access && pwrite;
   assign addr_ok = paddr inside {OFF_DIV_LOW, OFF_DIV_HIGH, OFF_CSA,
                                  OFF_CSC, OFF_DATA};
   assign wr_low = wr_acc && paddr == OFF_DIV_LOW;
   assign wr_high = wr_acc && paddr == OFF_DIV_HIGH;
   assign wr_csa = wr_acc && paddr == OFF_CSA;
   assign wr_csc = wr_acc && paddr == OFF_CSC;
   assign wr_data = wr_acc && paddr == OFF_DATA;
   assign rd_data = access && !pwrite && paddr == OFF_DATA;
   // Zero wait states keeps the software view simple
   assign pready = 1'b1;
   assign pslverr = access && !addr_ok;

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (paddr)
         OFF_DIV_LOW: next_rdata[7:0] = div_low;
         OFF_DIV_HIGH: next_rdata[3:0] = div_high_hold;
         OFF_CSA: begin
            next_rdata[CSA_DS] = double_speed;
            next_rdata[CSA_PE] = parity_error_flag;
            next_rdata[CSA_FE] = frame_error_flag;
            next_rdata[CSA_TC] = tx_complete_flag;
            next_rdata[CSA_RC] = rx_complete_flag;
         end
         OFF_CSC: begin
            next_rdata[CSC_CS+:3] = char_size;
            next_rdata[CSC_STOP] = stop_bit_select;
            next_rdata[CSC_PAR+:2] = parity_mode;
            next_rdata[CSC_SYNC] = sync_mode_select;
            next_rdata[CSC_POL] = clock_polarity;
            next_rdata[CSC_DIR] = xfer_clock_direction;
         end
         OFF_DATA: next_rdata[8:0] = rx_data;
         default: ;
      endcase
   end

   // Read data is captured in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // Divisor registers
   // ------------------------------------------------------------
   // Staging the high byte avoids a reload from a half-written value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_low <= DIV_RESET[7:0];
         div_high_hold <= DIV_RESET[11:8];
         baud_divisor <= DIV_RESET;
      end else if (wr_high) begin
         div_high_hold <= pwdata[3:0]; // RL26
      end else if (wr_low) begin
         div_low <= pwdata[7:0];
         baud_divisor <= {div_high_hold, pwdata[7:0]}; // RL6 RL26
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         double_speed <= 1'b0;
      end else if (wr_csa) begin
         double_speed <= pwdata[CSA_DS];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         char_size <= CS_RESET;
         stop_bit_select <= 1'b0;
         parity_mode <= 2'h0;
         sync_mode_select <= 1'b0;
         clock_polarity <= 1'b0;
         xfer_clock_direction <= 1'b0;
      end else if (wr_csc) begin
         char_size <= pwdata[CSC_CS+:3]; // RL17
         stop_bit_select <= pwdata[CSC_STOP];
         parity_mode <= pwdata[CSC_PAR+:2];
         sync_mode_select <= pwdata[CSC_SYNC];
         clock_polarity <= pwdata[CSC_POL];
         xfer_clock_direction <= pwdata[CSC_DIR];
      end
   end

   // ------------------------------------------------------------
   // Clock mode selection
   // ------------------------------------------------------------
   always_comb begin
      if (!sync_mode_select) begin // RL24
         mode = double_speed ? MODE_ASYNC_DBL : MODE_ASYNC; // RL7
      end else begin
         mode = xfer_clock_direction ? MODE_SYNC_MASTER
                                     : MODE_SYNC_SLAVE; // RL25
      end
   end

   assign is_async = !sync_mode_select;
   assign spb = (mode == MODE_ASYNC) ? SPB_NORM
              : (mode == MODE_ASYNC_DBL) ? SPB_DBL : SPB_SYNC; // RL5 RL8
   assign spb_m1 = spb - 5'h01;
   assign half = spb[4:1];

   baud_gen u_baud (
      .pclk(pclk),
      .presetn(presetn),
      .divisor(baud_divisor),
      .reload(wr_low),
      .tick(baud_tick)
   );

   xck_sync u_xck (
      .pclk(pclk),
      .presetn(presetn),
      .pin(xfer_clock_pin_in),
      .rise(xck_rise),
      .fall(xck_fall)
   );

   // ------------------------------------------------------------
   // Transfer clock and bit strobes
   // ------------------------------------------------------------
   // Master clock toggles on every tick; outside master mode it rests at the polarity level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xck_int <= 1'b0;
      end else if (mode != MODE_SYNC_MASTER) begin
         xck_int <= clock_polarity;
      end else if (baud_tick) begin
         xck_int <= !xck_int; // RL4
      end
   end

   assign xfer_clock_pin_out = xck_int;
   assign xfer_clock_pin_oe_n = (mode != MODE_SYNC_MASTER); // RL12

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_div <= 4'h0;
      end else if (!is_async) begin
         tx_div <= 4'h0;
      end else if (baud_tick) begin
         tx_div <= (tx_div == spb_m1[3:0]) ? 4'h0 : tx_div + 4'h1; // RL4
      end
   end

   always_comb begin
      unique case (mode) // RL1
         MODE_ASYNC, MODE_ASYNC_DBL: begin
            tx_en = baud_tick && tx_div == spb_m1[3:0];
            sync_samp = 1'b0;
         end
         MODE_SYNC_MASTER: begin
            tx_en = baud_tick && xck_int == clock_polarity; // RL14
            sync_samp = baud_tick && xck_int != clock_polarity; // RL13
         end
         MODE_SYNC_SLAVE: begin
            tx_en = clock_polarity ? xck_fall : xck_rise; // RL14
            sync_samp = clock_polarity ? xck_rise : xck_fall; // RL13
         end
      endcase
   end

   // ------------------------------------------------------------
   // Transmit framing
   // ------------------------------------------------------------
   assign nb = char_bits(char_size); // RL17 RL19

   always_comb begin
      tx_frame = 13'h1FFF;
      tx_frame[0] = 1'b0; // RL15
      for (int i = 0; i < 9; i++) begin
         if (i < int'(nb)) tx_frame[i+1] = tx_hold[i]; // RL27
      end
      if (parity_mode[1]) begin
         tx_frame[nb+4'h1] = par_bit(tx_hold, nb, parity_mode[0]); // RL20 RL21
      end
      tx_len = 4'h2 + nb + {3'h0, parity_mode[1]}
             + {3'h0, stop_bit_select}; // RL15
   end

   assign tx_load = tx_en && tx_cnt == 4'h0 && tx_pending;
   assign tx_done = tx_en && tx_cnt == 4'h0 && !tx_pending && tx_busy;

   // One staged character; a write while one waits is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_hold <= 9'h000;
         tx_pending <= 1'b0;
      end else if (tx_load) begin
         tx_pending <= 1'b0;
      end else if (wr_data && !tx_pending) begin
         tx_hold <= pwdata[8:0];
         tx_pending <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_out <= 1'b1;
         tx_shift <= 13'h1FFF;
         tx_cnt <= 4'h0;
         tx_busy <= 1'b0;
      end else if (tx_en) begin
         if (tx_cnt != 4'h0) begin
            serial_out <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[12:1]};
            tx_cnt <= tx_cnt - 4'h1;
         end else if (tx_pending) begin
            serial_out <= tx_frame[0]; // RL16
            tx_shift <= {1'b1, tx_frame[12:1]};
            tx_cnt <= tx_len - 4'h1;
            tx_busy <= 1'b1;
         end else begin
            serial_out <= 1'b1; // RL16
            tx_busy <= 1'b0;
         end
      end
   end

   // Set wins over the write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_complete_flag <= 1'b0;
      end else if (tx_done) begin
         tx_complete_flag <= 1'b1;
      end else if (wr_csa && pwdata[CSA_TC]) begin
         tx_complete_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Receive framing
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_meta <= 1'b1;
         rx_in <= 1'b1;
      end else begin
         rx_meta <= serial_in;
         rx_in <= rx_meta;
      end
   end

   assign rx_samp = is_async
      ? (baud_tick && rx_state != RX_IDLE && rx_phase == half) // RL5
      : sync_samp;
   // Only the first stop bit is looked at
   assign rx_finish = rx_state == RX_BITS && rx_samp
                      && rx_idx == nb + {3'h0, parity_mode[1]}; // RL18

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state <= RX_IDLE;
         rx_phase <= 4'h0;
         rx_idx <= 4'h0;
         rx_shift <= 9'h000;
         rx_par <= 1'b0;
      end else begin
         if (rx_state != RX_IDLE && baud_tick) begin
            rx_phase <= (rx_phase == spb_m1[3:0]) ? 4'h0
                                                  : rx_phase + 4'h1; // RL8
         end
         unique case (rx_state)
            RX_IDLE: begin
               if (is_async && baud_tick && !rx_in) begin
                  rx_state <= RX_START;
                  rx_phase <= 4'h0;
               end else if (!is_async && sync_samp && !rx_in) begin
                  rx_state <= RX_BITS;
                  rx_idx <= 4'h0;
                  rx_shift <= 9'h000;
               end
            end
            RX_START: begin
               if (rx_samp) begin
                  // A high mid-start sample was noise
                  rx_state <= rx_in ? RX_IDLE : RX_BITS;
                  rx_idx <= 4'h0;
                  rx_shift <= 9'h000;
               end
            end
            RX_BITS: begin
               if (rx_finish) begin
                  rx_state <= RX_IDLE;
               end else if (rx_samp) begin
                  if (rx_idx < nb) rx_shift[rx_idx] <= rx_in; // RL15
                  else rx_par <= rx_in; // RL21
                  rx_idx <= rx_idx + 4'h1;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data <= 9'h000;
         frame_error_flag <= 1'b0;
         parity_error_flag <= 1'b0;
      end else if (rx_finish) begin
         rx_data <= rx_shift;
         frame_error_flag <= !rx_in; // RL18
         parity_error_flag <= parity_mode[1]
            && (par_bit(rx_shift, nb, parity_mode[0]) != rx_par); // RL20
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_complete_flag <= 1'b0;
      end else if (rx_finish) begin
         rx_complete_flag <= 1'b1;
      end else if (rd_data) begin
         rx_complete_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_div_apply;
      @(posedge pclk) disable iff (!presetn)
      wr_low |=> baud_divisor == {$past(div_high_hold), $past(pwdata[7:0])};
   endproperty
   a_div_apply: assert property (p_div_apply) // RL26
      else $error("low byte write did not apply divisor");

   property p_high_held;
      @(posedge pclk) disable iff (!presetn)
      wr_high |=> $stable(baud_divisor);
   endproperty
   a_high_held: assert property (p_high_held) // RL26
      else $error("high byte write changed live divisor");

   property p_idle_high;
      @(posedge pclk) disable iff (!presetn)
      !tx_busy |-> serial_out;
   endproperty
   a_idle_high: assert property (p_idle_high) // RL16
      else $error("idle line not high");

   property p_start_low;
      @(posedge pclk) disable iff (!presetn)
      tx_load |=> !serial_out && tx_busy;
   endproperty
   a_start_low: assert property (p_start_low) // RL15
      else $error("frame did not begin with low start bit");

   property p_frame_err;
      @(posedge pclk) disable iff (!presetn)
      rx_finish |=> frame_error_flag == $past(!rx_in) && rx_complete_flag;
   endproperty
   a_frame_err: assert property (p_frame_err) // RL18
      else $error("frame error not taken from first stop bit");

   property p_sync_no_dbl;
      @(posedge pclk) disable iff (!presetn)
      sync_mode_select |-> spb == SPB_SYNC && mode != MODE_ASYNC_DBL;
   endproperty
   a_sync_no_dbl: assert property (p_sync_no_dbl) // RL7
      else $error("double speed acted in sync mode");

   property p_pin_dir;
      @(posedge pclk) disable iff (!presetn)
      xfer_clock_pin_oe_n == !(sync_mode_select && xfer_clock_direction);
   endproperty
   a_pin_dir: assert property (p_pin_dir) // RL12
      else $error("clock pin direction wrong for mode");

   property p_opposite_edges;
      @(posedge pclk) disable iff (!presetn)
      (mode == MODE_SYNC_MASTER && tx_en && !wr_csc)
         |-> !sync_samp ##1 xck_int == !clock_polarity;
   endproperty
   a_opposite_edges: assert property (p_opposite_edges) // RL13
      else $error("change and sample share a clock edge");
endmodule // usart_clock_and_framing

// File: core/usart_pkg.sv
// Shared constants, types and helpers for the serial clock and framing block
package usart_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFF_DIV_LOW = 12'h000;
   localparam logic [11:0] OFF_DIV_HIGH = 12'h004;
   localparam logic [11:0] OFF_CSA = 12'h008;
   localparam logic [11:0] OFF_CSC = 12'h00C;
   localparam logic [11:0] OFF_DATA = 12'h010;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CSA_DS = 1;
   localparam int CSA_PE = 2;
   localparam int CSA_FE = 4;
   localparam int CSA_TC = 6;
   localparam int CSA_RC = 7;
   localparam int CSC_CS = 0;
   localparam int CSC_STOP = 3;
   localparam int CSC_PAR = 4;
   localparam int CSC_SYNC = 6;
   localparam int CSC_POL = 7;
   localparam int CSC_DIR = 8;
   // ------------------------------------------------------------
   // Reset values and counts
   // ------------------------------------------------------------
   localparam logic [11:0] DIV_RESET = 12'h000;
   localparam logic [2:0] CS_RESET = 3'h3;
   localparam logic [4:0] SPB_NORM = 5'h10;
   localparam logic [4:0] SPB_DBL = 5'h08;
   localparam logic [4:0] SPB_SYNC = 5'h02;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_ASYNC, MODE_ASYNC_DBL, MODE_SYNC_MASTER, MODE_SYNC_SLAVE
   } mode_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_e;
   // Codes 4 to 6 are reserved and fall back to eight bits
   function automatic logic [3:0] char_bits(input logic [2:0] cs);
      if (cs == 3'h7) return 4'h9;
      if (cs[2]) return 4'h8;
      return 4'h5 + {2'h0, cs[1:0]};
   endfunction
   function automatic logic par_bit(input logic [8:0] d,
                                    input logic [3:0] nb,
                                    input logic odd);
      logic x;
      x = odd;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(nb)) x = x ^ d[i];
      end
      return x;
   endfunction
endpackage

// File: core/baud_gen.sv
// Programmable down-counter baud rate generator
`timescale 1ns/100ps
module baud_gen (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Divisor control
   input wire logic [11:0] divisor,
   input wire logic reload,
   // Generator output
   output logic tick
);
   import usart_pkg::*;
   logic [11:0] cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= DIV_RESET;
      end else if (reload || cnt == 12'h000) begin
         cnt <= divisor; // RL2
      end else begin
         cnt <= cnt - 12'h001;
      end
   end

   assign tick = (cnt == 12'h000); // RL3

   property p_reload_load;
      @(posedge pclk) disable iff (!presetn)
      reload |=> cnt == $past(divisor);
   endproperty
   a_reload_load: assert property (p_reload_load) // RL2
      else $error("counter did not reload with divisor");

   property p_tick_period;
      @(posedge pclk) disable iff (!presetn)
      (tick && !reload && divisor == 12'h002)
      ##1 (!reload && divisor == 12'h002) [*2] |=> tick && $past(!tick);
   endproperty
   a_tick_period: assert property (p_tick_period) // RL3
      else $error("generator period is not divisor plus one");
endmodule // baud_gen

// File: core/xck_sync.sv
// Synchroniser and edge detector for the external transfer clock
`timescale 1ns/100ps
module xck_sync (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pin level and edge strobes
   input wire logic pin,
   output logic rise,
   output logic fall
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin; // RL9
         s2 <= s1;
         s3 <= s2;
      end
   end

   assign rise = s2 && !s3; // RL9 RL10
   assign fall = !s2 && s3;

   property p_edge_latency;
      @(posedge pclk) disable iff (!presetn)
      (rise && $past(presetn, 3)) |-> $past(pin, 2) && !$past(pin, 3);
   endproperty
   a_edge_latency: assert property (p_edge_latency) // RL10
      else $error("pin edge not seen two cycles later");
endmodule // xck_sync

// File: tb/usart_remote.sv
// Remote serial device model on the receive line
`timescale 1ns/100ps
module usart_remote (
   // Clock and lines
   input wire logic pclk,
   output logic line,
   output logic xck
);
   // Clock held still: no slave frames are sent
   initial begin
      line = 1'b1;
      xck = 1'b0;
   end
   task send(input logic [8:0] d, input int nb, input int per);
      line <= 1'b0;
      repeat (per) @(posedge pclk);
      for (int i = 0; i < nb; i++) begin
         line <= d[i];
         repeat (per) @(posedge pclk);
      end
      line <= 1'b1;
      repeat (per) @(posedge pclk);
   endtask
endmodule // usart_remote

// File: tb/usart_clock_and_framing_bench.sv
// Self-checking bench for the serial clock and framing block
`timescale 1ns/100ps
module usart_clock_and_framing_bench;
   import usart_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic pready, pslverr, so, ck_o, oe_n, line, rck, e;
   wire pin = oe_n ? rck : ck_o;
   int err_count = 0, n_tests = 0, cyc = 0;
   usart_clock_and_framing uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_in(line), .serial_out(so),
      .xfer_clock_pin_in(pin), .xfer_clock_pin_out(ck_o),
      .xfer_clock_pin_oe_n(oe_n));
   usart_remote rem (.pclk(pclk), .line(line), .xck(rck));
   always #20 pclk = ~pclk;
   // Hang guard, well above the expected run
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   task results;
      $display("errors %0d of %0d checks", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Expected frame built bit by bit, then sampled mid-bit
   task tx(input logic [8:0] d, input int nb, pm, sb, per);
      logic [12:0] f;
      logic p;
      int n;
      f = '0;
      n = 1;
      p = pm[0];
      for (int i = 0; i < nb; i++) begin
         f[n] = d[i];
         p = p ^ d[i];
         n++;
      end
      if (pm[1]) begin
         f[n] = p;
         n++;
      end
      for (int i = 0; i < sb; i++) begin
         f[n] = 1'b1;
         n++;
      end
      xfer(0, OFF_CSA, 0);
      xfer(1, OFF_CSA, r | (32'h1 << CSA_TC));
      xfer(1, OFF_DATA, {23'h0, d});
      // Line is sampled on the falling edge, where it has settled
      while (so !== 1'b0) @(negedge pclk);
      repeat (per / 2) @(negedge pclk);
      for (int i = 0; i < n; i++) begin
         cmp(so, f[i]);
         repeat (per) @(negedge pclk);
      end
      xfer(0, OFF_CSA, 0);
      cmp(r[CSA_TC], 1'b1);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      cmp(so, 1'b1);
      xfer(0, OFF_CSC, 0);
      cmp(r, 32'h3);
      xfer(0, 12'h020, 0);
      cmp({r[30:0], e}, 32'h1);
      xfer(1, OFF_DIV_HIGH, 0);
      xfer(1, OFF_DIV_LOW, 2);
      tx(9'h055, 8, 0, 1, 48);
      xfer(1, OFF_CSA, 2);
      xfer(1, OFF_CSC, 32'h28);
      tx(9'h1AA, 5, 2, 2, 24);
      xfer(1, OFF_CSC, 32'h32);
      tx(9'h0C3, 7, 3, 1, 24);
      xfer(1, OFF_CSC, 32'h7);
      tx(9'h1A5, 9, 0, 1, 24);
      xfer(1, OFF_CSA, 0);
      xfer(1, OFF_CSC, 32'h3);
      @(posedge pclk);
      rem.send(9'h0A3, 8, 48);
      repeat (40) @(posedge pclk);
      xfer(0, OFF_CSA, 0);
      cmp({r[CSA_RC], r[CSA_FE]}, 2'b10);
      xfer(0, OFF_DATA, 0);
      cmp(r[7:0], 8'hA3);
      xfer(1, OFF_CSC, 32'h143);
      @(negedge pclk);
      cmp(oe_n, 1'b0);
      tx(9'h05A, 8, 0, 1, 6);
      xfer(1, OFF_CSC, 32'hC3);
      repeat (2) @(negedge pclk);
      cmp(oe_n, 1'b1);
      cmp(ck_o, 1'b1);
      results();
   end
endmodule // usart_clock_and_framing_bench
